// ===== hdl/emb_ext_mem.sv
// External memory interface with overlay decode, I/O wait states, composite select and byte DMA.
// Assumes all inputs are synchronous to mclk and that on-chip memory answers reads in the same cycle.
`default_nettype none
module emb_ext_mem
    import emb_pkg::*;
(
    input  wire logic        mclk,           // Processor clock
    input  wire logic        sys_rst,        // Synchronous reset
    input  wire logic        hostMode,       // Host memory mode strap
    input  wire logic        bootByteMem,    // Byte memory boot selected
    input  wire logic [3:0]  regAddr,        // Register index
    input  wire logic [15:0] regWrData,      // Register write data
    input  wire logic        regWr,          // Register write strobe
    input  wire logic        regRd,          // Register read strobe
    output logic      [15:0] regRdData,      // Read data, cycle after strobe
    input  wire logic        coreReq,        // Core memory request, held to ack
    input  wire emb_space_t  coreSpace,      // Program, data or I/O
    input  wire logic        coreFetch,      // Request is an instruction fetch
    input  wire logic        coreWrite,      // Write request
    input  wire logic [13:0] coreAddr,       // Core address
    input  wire logic [23:0] coreWrData,     // Core write data
    output logic             coreAck,        // Access complete
    output logic             coreIsExt,      // Request goes off chip
    output logic      [23:0] coreRdData,     // External read data, cycle after ack
    output logic             coreHold,       // Core held during DMA
    output logic             coreRestart,    // Clear context and resume at 0
    output logic             memReq,         // On-chip access by DMA
    output logic             memWr,          // On-chip write
    output logic             memIsPm,        // Program memory target
    output logic      [3:0]  memOvl,         // Internal overlay block
    output logic      [13:0] memAddr,        // On-chip address
    output logic      [23:0] memWrData,      // On-chip write data
    input  wire logic [23:0] memRdData,      // On-chip read data, same cycle
    output logic             bdmaDone,       // Transfer finished pulse
    output logic      [13:0] extAddr,        // External address pins
    output logic      [23:0] extDataOut,     // External data out
    output logic      [2:0]  extDataOe,      // Byte lane enables, high drives
    input  wire logic [23:0] extDataIn,      // External data in
    output logic             rdN,            // Read strobe
    output logic             wrN,            // Write strobe
    output logic             pmsN,           // Program memory select
    output logic             dmsN,           // Data memory select
    output logic             bmsN,           // Byte memory select
    output logic             iomsN,          // I/O space select
    output logic             cmsN            // Composite select
);
    typedef enum logic [1:0] {BUS_IDLE, BUS_CORE, BUS_BYTE} emb_bus_t;
    typedef enum logic [1:0] {BD_IDLE, BD_FETCH, BD_BYTES, BD_STORE} emb_bd_t;

    logic [11:0] waitsQ;
    logic [15:0] sysQ, ctlQ;
    logic [3:0]  cmsEnQ;
    logic [7:0]  ovlQ, bOvlQ;
    logic [13:0] biadQ, beadQ, countQ;
    logic [15:0] rdData_q;
    emb_bus_t    busSt_q;
    emb_bd_t     bdSt_q;
    logic [2:0]  waitCnt_q, accWaits_q;
    logic [13:0] accAddr_q;
    logic [23:0] accData_q, coreRd_q, shift_q;
    logic        accWr_q, accPm_q;
    logic [3:0]  accSel_q;
    logic [1:0]  bytesLeft_q;

    // Register decode
    wire wrWaits = regWr && regAddr == REG_WAITS;
    wire wrSys   = regWr && regAddr == REG_SYSCTL;
    wire wrCms   = regWr && regAddr == REG_COMPOSITE_SELECT_ENABLES;
    wire wrOvl   = regWr && regAddr == REG_OVLAY;
    wire wrCtl   = regWr && regAddr == REG_BDCTL;
    wire wrBiad  = regWr && regAddr == REG_INTERNAL_START_ADDRESS;
    wire wrBead  = regWr && regAddr == REG_EXTERNAL_START_ADDRESS;
    wire wrCount = regWr && regAddr == REG_BCOUNT;
    wire wrBOvl  = regWr && regAddr == REG_BOVLAY;
    wire [1:0] fmt    = ctlQ[CTL_TYPE +: 2];
    wire       toByte = ctlQ[CTL_DIR];
    wire       ctx    = ctlQ[CTL_CTX];
    wire [7:0] pageQ  = ctlQ[CTL_PAGE +: 8];
    wire       busy   = countQ != ZERO_COUNT;

    // Core request decode; a window hit is bit 13 of the address
    wire [3:0] ovlSel = (coreSpace == SP_PM) ? ovlQ[3:0] : ovlQ[OVL_DM +: 4];
    wire ovlExt = coreAddr[13] && (ovlSel == OVL_EXT1 || ovlSel == OVL_EXT2);
    assign coreIsExt = coreSpace == SP_IO || (ovlExt && !(hostMode && coreFetch));
    wire [2:0] ioWait = waitsQ[3 * coreAddr[10:9] +: 3];
    wire [2:0] coreWait = (coreSpace == SP_IO) ? ioWait
                        : (coreSpace == SP_DM) ? sysQ[SYS_DMWAIT +: 3] : sysQ[SYS_PMWAIT +: 3];
    wire [13:0] ovlAddr = hostMode ? {13'h0000, coreAddr[0]} : {ovlSel == OVL_EXT2, coreAddr[12:0]};
    wire [13:0] coreExtAddr = (coreSpace == SP_IO) ? {3'h0, coreAddr[10:0]} : ovlAddr;
    wire [3:0] coreSel = (coreSpace == SP_IO) ? 4'h8 : (coreSpace == SP_DM) ? 4'h2 : 4'h1;
    wire [23:0] coreOut = (coreSpace == SP_PM) ? coreWrData : {coreWrData[15:0], 8'h00};

    // Bus arbitration: the core wins whenever the bus is free
    wire byteWant  = bdSt_q == BD_BYTES;
    wire coreStart = busSt_q == BUS_IDLE && coreReq && coreIsExt;
    wire byteStart = busSt_q == BUS_IDLE && !(coreReq && coreIsExt) && byteWant;
    wire accLast   = busSt_q != BUS_IDLE && waitCnt_q == 3'h0;
    wire byteDone  = accLast && busSt_q == BUS_BYTE;
    assign coreAck = (coreReq && !coreIsExt) || (accLast && busSt_q == BUS_CORE);
    wire [13:0] byteAddr = hostMode ? {13'h0000, beadQ[0]} : beadQ;

    // External access state; each access lasts its wait count plus one cycle
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            busSt_q   <= BUS_IDLE;
            waitCnt_q <= 3'h0;
        end else if (coreStart) begin
            busSt_q   <= BUS_CORE;
            waitCnt_q <= coreWait;
        end else if (byteStart) begin
            busSt_q   <= BUS_BYTE;
            waitCnt_q <= sysQ[SYS_BYTE_MEMORY_WAIT_SETTING +: 3];
        end else if (accLast) begin
            busSt_q   <= BUS_IDLE;
        end else if (busSt_q != BUS_IDLE) begin
            waitCnt_q <= waitCnt_q - 3'h1;
        end
    end

    // Latched address, data and select of the running access
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            accAddr_q  <= 14'h0000;
            accData_q  <= 24'h000000;
            accWr_q    <= 1'b0;
            accPm_q    <= 1'b0;
            accSel_q   <= 4'h0;
            accWaits_q <= 3'h0;
        end else if (coreStart) begin
            accAddr_q  <= coreExtAddr;
            accData_q  <= coreOut;
            accWr_q    <= coreWrite;
            accPm_q    <= coreSpace == SP_PM;
            accSel_q   <= coreSel;
            accWaits_q <= coreWait;
        end else if (byteStart) begin
            accAddr_q  <= byteAddr;
            accData_q  <= {pageQ, shift_q[23:16], 8'h00};
            accWr_q    <= toByte;
            accPm_q    <= 1'b0;
            accSel_q   <= 4'h4;
            accWaits_q <= sysQ[SYS_BYTE_MEMORY_WAIT_SETTING +: 3];
        end else if (accLast) begin
            accSel_q   <= 4'h0;
            accWr_q    <= 1'b0;
        end
    end

    // Core read data captured on the last access cycle
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            coreRd_q <= 24'h000000;
        end else if (accLast && busSt_q == BUS_CORE && !accWr_q) begin
            coreRd_q <= accPm_q ? extDataIn : {8'h00, extDataIn[23:8]};
        end
    end
    assign coreRdData = coreRd_q;

    // Pins; strobes last for the whole access
    wire active = busSt_q != BUS_IDLE;
    assign extAddr    = accAddr_q;
    assign extDataOut = accData_q;
    assign extDataOe  = !active ? 3'h0 : busSt_q == BUS_BYTE ? {1'b1, accWr_q, 1'b0}
                      : !accWr_q ? 3'h0 : accPm_q ? 3'h7 : 3'h6;
    assign rdN   = !(active && !accWr_q);
    assign wrN   = !(active && accWr_q);
    assign pmsN  = !accSel_q[SEL_PMS];
    assign dmsN  = !accSel_q[SEL_DMS];
    assign bmsN  = !(accSel_q[SEL_BMS] && !sysQ[SYS_BMSDIS]);
    assign iomsN = !accSel_q[SEL_IO_SPACE_SELECT];
    assign cmsN  = !(|(accSel_q & cmsEnQ));

    // Byte DMA word format handling
    wire [1:0] need = (fmt == FMT_PM24) ? 2'h3 : (fmt == FMT_DM16) ? 2'h2 : 2'h1;
    wire [23:0] alignOut = (fmt == FMT_PM24) ? memRdData
                         : (fmt == FMT_DM16) ? {memRdData[15:0], 8'h00}
                         : (fmt == FMT_DMMSB) ? {memRdData[15:8], 16'h0000} : {memRdData[7:0], 16'h0000};
    wire [23:0] alignIn = (fmt == FMT_PM24) ? shift_q
                        : (fmt == FMT_DM16) ? {8'h00, shift_q[15:0]}
                        : (fmt == FMT_DMMSB) ? {8'h00, shift_q[7:0], 8'h00} : {16'h0000, shift_q[7:0]};
    wire lastByte = byteDone && bytesLeft_q == 2'h1;
    wire wordDone = bdSt_q == BD_STORE || (lastByte && toByte);
    wire [21:0] nextByteAddr = {pageQ, beadQ} + 22'h000001;

    // DMA sequencer: fetch word, move bytes, store word
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            bdSt_q      <= BD_IDLE;
            bytesLeft_q <= 2'h0;
            shift_q     <= 24'h000000;
        end else begin
            unique case (bdSt_q)
                BD_IDLE: begin
                    if (busy) begin
                        bdSt_q      <= toByte ? BD_FETCH : BD_BYTES;
                        bytesLeft_q <= need;
                    end
                end
                BD_FETCH: begin
                    shift_q <= alignOut;
                    bdSt_q  <= BD_BYTES;
                end
                BD_BYTES: begin
                    if (byteDone) begin
                        shift_q     <= toByte ? {shift_q[15:0], 8'h00} : {shift_q[15:0], extDataIn[15:8]};
                        bytesLeft_q <= bytesLeft_q - 2'h1;
                        if (lastByte) begin
                            bdSt_q <= toByte ? BD_IDLE : BD_STORE;
                        end
                    end
                end
                BD_STORE: begin
                    bdSt_q <= BD_IDLE;
                end
            endcase
        end
    end

    // One on-chip cycle per word
    assign memReq    = bdSt_q == BD_FETCH || bdSt_q == BD_STORE;
    assign memWr     = bdSt_q == BD_STORE;
    assign memIsPm   = fmt == FMT_PM24;
    assign memOvl    = memIsPm ? bOvlQ[3:0] : bOvlQ[OVL_DM +: 4];
    assign memAddr   = biadQ;
    assign memWrData = alignIn;
    assign bdmaDone  = wordDone && countQ == 14'h0001;
    assign coreHold  = ctx && busy;
    assign coreRestart = bdmaDone && ctx;

    // Software registers; boot strap presets the DMA at reset
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            waitsQ <= 12'h000;
            sysQ   <= 16'h0000;
            cmsEnQ <= COMPOSITE_SELECT_ENABLES_RST;
            ovlQ   <= 8'h00;
            bOvlQ  <= 8'h00;
            ctlQ   <= {12'h000, bootByteMem, 3'h0};
            biadQ  <= 14'h0000;
            beadQ  <= 14'h0000;
            countQ <= bootByteMem ? BOOT_COUNT : ZERO_COUNT;
        end else begin
            if (wrWaits) waitsQ <= regWrData[11:0];
            if (wrSys) sysQ <= regWrData;
            if (wrCms) cmsEnQ <= regWrData[3:0];
            if (wrOvl) ovlQ <= regWrData[7:0];
            if (wrBOvl) bOvlQ <= regWrData[7:0];
            if (wrBiad) biadQ <= regWrData[13:0];
            else if (wordDone) biadQ <= biadQ + 14'h0001;
            if (wrCount) countQ <= regWrData[13:0];
            else if (wordDone) countQ <= countQ - 14'h0001;
            if (wrCtl) ctlQ <= regWrData;
            else if (byteDone) ctlQ[CTL_PAGE +: 8] <= nextByteAddr[21:14];
            if (wrBead) beadQ <= regWrData[13:0];
            else if (byteDone) beadQ <= nextByteAddr[13:0];
        end
    end

    // Register read port, data one cycle after the strobe
    wire [15:0] rdMux = (regAddr == REG_WAITS) ? {4'h0, waitsQ}
                      : (regAddr == REG_SYSCTL) ? sysQ
                      : (regAddr == REG_COMPOSITE_SELECT_ENABLES) ? {12'h000, cmsEnQ}
                      : (regAddr == REG_OVLAY) ? {8'h00, ovlQ}
                      : (regAddr == REG_BDCTL) ? ctlQ
                      : (regAddr == REG_INTERNAL_START_ADDRESS) ? {2'h0, biadQ}
                      : (regAddr == REG_EXTERNAL_START_ADDRESS) ? {2'h0, beadQ}
                      : (regAddr == REG_BCOUNT) ? {2'h0, countQ}
                      : (regAddr == REG_BOVLAY) ? {8'h00, bOvlQ}
                      : (regAddr == REG_STATUS) ? {14'h0000, coreHold, busy} : 16'h0000;
    always_ff @(posedge mclk) begin
        if (sys_rst) rdData_q <= 16'h0000;
        else rdData_q <= regRd ? rdMux : 16'h0000;
    end
    assign regRdData = rdData_q;

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    logic [2:0] accLen_q;
    always_ff @(posedge mclk) begin
        if (sys_rst || !active) accLen_q <= 3'h0;
        else accLen_q <= accLen_q + 3'h1;
    end

    sequence sPmOvlStart;
        coreStart && coreSpace == SP_PM && !hostMode;
    endsequence
    sequence sByteCarry;
        byteDone && beadQ == 14'h3FFF && !wrCtl && !wrBead;
    endsequence

    a_internal_one_cycle: assert property (coreReq && !coreIsExt |-> coreAck)
        else $error("internal access not acked at once");
    a_pm_overlay_addr: assert property (sPmOvlStart |=> extAddr[13] == (ovlQ[3:0] == OVL_EXT2) && !pmsN)
        else $error("program overlay address bit wrong");
    a_io_wait_len: assert property (accLast && accSel_q[SEL_IO_SPACE_SELECT] |-> accLen_q == accWaits_q && !iomsN)
        else $error("io access length differs from region wait");
    a_io_high_bits: assert property (!iomsN |-> extAddr[13:11] == 3'h0)
        else $error("io access drives upper address bits");
    a_cms_follows: assert property (!dmsN && cmsEnQ[SEL_DMS] |-> !cmsN)
        else $error("composite select missed data select");
    a_bms_disabled: assert property (sysQ[SYS_BMSDIS] |-> bmsN)
        else $error("byte select not suppressed");
    a_core_first: assert property (coreReq && coreIsExt && busSt_q == BUS_IDLE |=> busSt_q == BUS_CORE)
        else $error("byte access taken before core");
    a_word_cycle: assert property (memReq |=> !memReq)
        else $error("on-chip transfer longer than one cycle");
    a_count_step: assert property (wordDone && !wrCount |=> countQ == $past(countQ) - 14'h0001)
        else $error("word count not decremented");
    a_page_carry: assert property (sByteCarry |=> pageQ == $past(pageQ) + 8'h01 && beadQ == 14'h0000)
        else $error("page not advanced across boundary");
endmodule : emb_ext_mem
`default_nettype wire

// ===== hdl/emb_pkg.sv
// Package for the external memory interface and byte-memory DMA block.
// Assumes one processor clock; the register offsets and field positions are shared with software.
`default_nettype none
package emb_pkg;
    // Register offsets on the plain register port
    localparam logic [3:0] REG_WAITS   = 4'h0;
    localparam logic [3:0] REG_SYSCTL  = 4'h1;
    localparam logic [3:0] REG_COMPOSITE_SELECT_ENABLES  = 4'h2;
    localparam logic [3:0] REG_OVLAY   = 4'h3;
    localparam logic [3:0] REG_BDCTL   = 4'h4;
    localparam logic [3:0] REG_INTERNAL_START_ADDRESS    = 4'h5;
    localparam logic [3:0] REG_EXTERNAL_START_ADDRESS    = 4'h6;
    localparam logic [3:0] REG_BCOUNT  = 4'h7;
    localparam logic [3:0] REG_BOVLAY  = 4'h8;
    localparam logic [3:0] REG_STATUS  = 4'h9;
    // Field positions
    localparam int SYS_BMSDIS = 3;
    localparam int SYS_BYTE_MEMORY_WAIT_SETTING = 4;
    localparam int SYS_DMWAIT = 8;
    localparam int SYS_PMWAIT = 12;
    localparam int CTL_TYPE   = 0;
    localparam int CTL_DIR    = 2;
    localparam int CTL_CTX    = 3;
    localparam int CTL_PAGE   = 8;
    localparam int OVL_DM     = 4;
    localparam int SEL_PMS    = 0;
    localparam int SEL_DMS    = 1;
    localparam int SEL_BMS    = 2;
    localparam int SEL_IO_SPACE_SELECT   = 3;
    // Reset values
    localparam logic [3:0]  COMPOSITE_SELECT_ENABLES_RST = 4'hB;
    localparam logic [13:0] BOOT_COUNT = 14'h0020;
    localparam logic [13:0] ZERO_COUNT = 14'h0000;
    // Overlay codes that reach external memory
    localparam logic [3:0] OVL_EXT1 = 4'h1;
    localparam logic [3:0] OVL_EXT2 = 4'h2;
    // Word formats
    localparam logic [1:0] FMT_PM24  = 2'h0;
    localparam logic [1:0] FMT_DM16  = 2'h1;
    localparam logic [1:0] FMT_DMMSB = 2'h2;
    typedef enum logic [1:0] {SP_PM, SP_DM, SP_IO} emb_space_t;
endpackage : emb_pkg
`default_nettype wire

// ===== verif/emb_ext_model.sv
// Behavioural byte-wide ROM and I/O peripheral on the far side of the external bus.
// Assumes the bench merges this drive with the block's own lane enables.
`default_nettype none
module emb_ext_model
    import emb_pkg::*;
(
    input  wire logic        mclk,       // Processor clock
    input  wire logic [13:0] extAddr,    // Address pins
    input  wire logic [23:0] extDataOut, // Block data drive
    input  wire logic [2:0]  extDataOe,  // Block lane enables
    input  wire logic        rdN,        // Read strobe
    output logic      [23:0] drive       // Model drive toward the block
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] lastQ = 24'h000000;
    logic [7:0]  pageSel;
    // Page lines only matter while the block drives them in a byte access
    assign pageSel = extDataOe[2] ? extDataOut[23:16] : 8'h00;
    // Released bus flips every cycle, so stale data can never pass for fresh
    assign drive = !rdN ? {~extAddr[7:0], extAddr[7:0] ^ pageSel, 8'h00} : ~lastQ;
    always_ff @(posedge mclk) begin
        lastQ <= drive;
    end
endmodule : emb_ext_model
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the external memory interface and byte DMA block.
// Assumes the partner model answers reads without waits and byte boot is off.
`default_nettype none
module tb_top;
    import emb_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, sys_rst, hostMode, regWr, regRd, coreReq, coreFetch;
    logic [3:0] regAddr;
    logic [15:0] regWrData, regRdData;
    emb_space_t coreSpace;
    logic [13:0] coreAddr, memAddr, extAddr;
    logic [23:0] coreRdData, memWrData, extDataOut, extDataIn, modelDrive;
    logic [3:0] memOvl;
    logic [2:0] extDataOe;
    logic coreAck, coreIsExt, coreHold, coreRestart, memReq, memWr, memIsPm, bdmaDone;
    logic rdN, wrN, pmsN, dmsN, bmsN, iomsN, cmsN;
    int miscompares = 0;
    int numChecks = 0;
    int cycles = 0;
    emb_ext_mem u_dut (.mclk(mclk), .sys_rst(sys_rst), .hostMode(hostMode), .bootByteMem(1'b0),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .coreReq(coreReq), .coreSpace(coreSpace), .coreFetch(coreFetch), .coreWrite(1'b0),
        .coreAddr(coreAddr), .coreWrData(24'h000000), .coreAck(coreAck), .coreIsExt(coreIsExt),
        .coreRdData(coreRdData), .coreHold(coreHold), .coreRestart(coreRestart), .memReq(memReq),
        .memWr(memWr), .memIsPm(memIsPm), .memOvl(memOvl), .memAddr(memAddr), .memWrData(memWrData),
        .memRdData(24'h000000), .bdmaDone(bdmaDone), .extAddr(extAddr), .extDataOut(extDataOut),
        .extDataOe(extDataOe), .extDataIn(extDataIn), .rdN(rdN), .wrN(wrN), .pmsN(pmsN), .dmsN(dmsN),
        .bmsN(bmsN), .iomsN(iomsN), .cmsN(cmsN));
    emb_ext_model u_mem (.mclk(mclk), .extAddr(extAddr), .extDataOut(extDataOut), .extDataOe(extDataOe),
        .rdN(rdN), .drive(modelDrive));
    // Each data lane is driven by whichever side enables it
    assign extDataIn[23:16] = extDataOe[2] ? extDataOut[23:16] : modelDrive[23:16];
    assign extDataIn[15:8]  = extDataOe[1] ? extDataOut[15:8] : modelDrive[15:8];
    assign extDataIn[7:0]   = extDataOe[0] ? extDataOut[7:0] : modelDrive[7:0];
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge mclk) begin
        cycles++;
        if (cycles > 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish;
        if (miscompares == 0 && numChecks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        numChecks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [7:0] byteAt(input logic [21:0] a);
        return a[7:0] ^ a[21:14];
    endfunction : byteAt
    task automatic regWrite(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask : regWrite
    task automatic regRead(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRd <= 1'b0;
        @(negedge mclk);
        d = regRdData;
    endtask : regRead
    // One core access; counts read strobe cycles and snapshots pins at the first one
    task automatic coreAccess(input emb_space_t sp, input logic fetch, input logic [13:0] a, output logic isExt,
                              output int strobes, output logic [13:0] pinAddr, output logic [3:0] sels,
                              output logic [23:0] rd);
        int guard;
        @(posedge mclk);
        coreReq <= 1'b1;
        coreSpace <= sp;
        coreFetch <= fetch;
        coreAddr <= a;
        strobes = 0;
        guard = 0;
        @(negedge mclk);
        isExt = coreIsExt;
        while (coreAck !== 1'b1 && guard < 50) begin
            @(negedge mclk);
            guard++;
            if (rdN === 1'b0 && strobes == 0) begin
                pinAddr = extAddr;
                sels = {pmsN, dmsN, iomsN, cmsN};
            end
            strobes += (rdN === 1'b0);
        end
        @(posedge mclk);
        coreReq <= 1'b0;
        @(negedge mclk);
        rd = (sp == SP_PM) ? coreRdData : {8'h00, coreRdData[15:0]};
    endtask : coreAccess
    task automatic overlayScan;
        logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5};
        logic ext, e;
        int n;
        logic [13:0] pa;
        logic [3:0] s;
        logic [23:0] rd;
        regWrite(REG_SYSCTL, 16'h0300);
        for (int i = 0; i < 10; i++) begin
            regWrite(REG_OVLAY, {8'h00, codes[i % 5], codes[i % 5]});
            coreAccess((i < 5) ? SP_PM : SP_DM, 1'b0, 14'h2345, ext, n, pa, s, rd);
            e = (codes[i % 5] == OVL_EXT1) || (codes[i % 5] == OVL_EXT2);
            chk({23'h0, ext}, {23'h0, e});
            chk(24'(n), e ? ((i < 5) ? 24'd1 : 24'd4) : 24'd0);
            if (e) begin
                chk({10'h0, pa}, {10'h0, codes[i % 5] == OVL_EXT2, 13'h0345});
                chk({20'h0, s}, (i < 5) ? 24'h6 : 24'hA);
                chk(rd, (i < 5) ? 24'hBA4500 : 24'h00BA45);
            end
        end
    endtask : overlayScan
    task automatic ioScan;
        logic ext;
        int n;
        logic [13:0] pa, a;
        logic [3:0] s;
        logic [23:0] rd;
        regWrite(REG_WAITS, 16'h08D1);
        for (int r = 0; r < 4; r++) begin
            a = 14'(r * 14'h200 + 14'h50 + r);
            coreAccess(SP_IO, 1'b0, a, ext, n, pa, s, rd);
            chk(24'(n), 24'(r + 2));
            chk({13'h0, pa[10:0]}, {13'h0, a[10:0]});
            chk({20'h0, s}, 24'hC);
            chk(rd, {8'h00, ~a[7:0], a[7:0]});
        end
    endtask : ioScan
    task automatic dmaRun(input logic [1:0] t, input logic ctx, output int bmsLow, output int cmsLow);
        int nb, k, guard;
        logic [21:0] a;
        logic [23:0] w, exp;
        logic [15:0] rd;
        nb = (t == FMT_PM24) ? 3 : (t == FMT_DM16) ? 2 : 1;
        k = 0;
        guard = 0;
        bmsLow = 0;
        cmsLow = 0;
        regWrite(REG_BDCTL, {8'h05, 4'h0, ctx, 1'b0, t});
        regWrite(REG_INTERNAL_START_ADDRESS, 16'h0100);
        regWrite(REG_EXTERNAL_START_ADDRESS, 16'h3FFE);
        regWrite(REG_BCOUNT, 16'h0002);
        // Page and address advance with every byte, carrying into the page
        while (bdmaDone !== 1'b1 && guard < 300) begin
            @(negedge mclk);
            guard++;
            bmsLow += (bmsN === 1'b0);
            cmsLow += (cmsN === 1'b0);
            if (memReq === 1'b1) begin
                a = 22'h017FFE + 22'(k * nb);
                w = {byteAt(a), byteAt(a + 22'd1), byteAt(a + 22'd2)};
                exp = (t == FMT_PM24) ? w : (t == FMT_DM16) ? {8'h00, w[23:8]} :
                      (t == FMT_DMMSB) ? {8'h00, w[23:16], 8'h00} : {16'h0000, w[23:16]};
                chk(memWrData, exp);
                chk({8'h00, memIsPm, memWr, memAddr}, {8'h00, t == FMT_PM24, 1'b1, 14'h0100 + 14'(k)});
                chk({22'h0, coreHold, coreRestart}, {22'h0, ctx, ctx && k == 1});
                k++;
            end
        end
        chk(24'(k), 24'd2);
        regRead(REG_BCOUNT, rd);
        chk({8'h00, rd}, 24'h000000);
    endtask : dmaRun
    task automatic dmaScan;
        int b, c;
        regWrite(REG_SYSCTL, 16'h0000);
        for (int t = 0; t < 4; t++) begin
            dmaRun(2'(t), 1'b0, b, c);
            chk({23'h0, b != 0}, 24'h1);
            chk({23'h0, c != 0}, 24'h0);
        end
        regWrite(REG_SYSCTL, 16'h0008);
        regWrite(REG_COMPOSITE_SELECT_ENABLES, 16'h000F);
        dmaRun(FMT_DM16, 1'b1, b, c);
        chk({23'h0, b != 0}, 24'h0);
        chk({23'h0, c != 0}, 24'h1);
    endtask : dmaScan
    task automatic hostScan;
        logic ext;
        int n;
        logic [13:0] pa;
        logic [3:0] s;
        logic [23:0] rd;
        @(posedge mclk);
        hostMode <= 1'b1;
        regWrite(REG_OVLAY, 16'h0021);
        coreAccess(SP_PM, 1'b1, 14'h2345, ext, n, pa, s, rd);
        chk({23'h0, ext}, 24'h0);
        coreAccess(SP_DM, 1'b0, 14'h2345, ext, n, pa, s, rd);
        chk({23'h0, pa[0]}, 24'h1);
        @(posedge mclk);
        hostMode <= 1'b0;
    endtask : hostScan
    initial begin
        logic [15:0] rd;
        sys_rst = 1'b1;
        hostMode = 1'b0;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 4'h0;
        regWrData = 16'h0000;
        coreReq = 1'b0;
        coreSpace = SP_PM;
        coreFetch = 1'b0;
        coreAddr = 14'h0000;
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        regRead(REG_COMPOSITE_SELECT_ENABLES, rd);
        chk({8'h00, rd}, 24'h00000B);
        regRead(4'hF, rd);
        chk({8'h00, rd}, 24'h000000);
        overlayScan();
        ioScan();
        hostScan();
        dmaScan();
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
